/* File: core/stage_cfg_pkg.sv */
// Functional notes
// [RULE1] power-up profile from stored select, 1..4, default 1; the load follows a reset of the select, so it is always 1
// [RULE2] four profiles: min, max, 1..1000 ms ramp
// [RULE3] host keeps each profile minimum below maximum
// [RULE4] selected profile drives joystick and program motion
// [RULE5] output polarity: idle low default, idle high option
// [RULE6] serial rate 9600/38400/57600, default 38400
// [RULE7] 8 data bits, no parity, 1 stop, CR LF
// [RULE8] RTS/CTS handshake or none, handshake default
// [RULE9] per axis display unit pulse/um/degree, um default
// [RULE10] per axis travel per pulse, 1..1000000, division 40
// [RULE11] degree unit reads travel in micro-degrees
// [RULE12] per axis direction mapping, positive default
// [RULE13] per axis homing method 0..6, default 1
// [RULE14] offset after homing methods one, five, six
// [RULE15] zero offset means half a millimetre
// [RULE16] per axis auto setup switch, default on
// [RULE17] host power-cycles after changing stored settings
// [RULE18] method zero performs no homing on that axis
// [RULE19] load store once at power-up, ignore later updates
package stage_cfg_pkg;
	// ------------
	// register map, byte addresses
	// ------------
	localparam logic [11:0] ADDR_PROFILE_SEL = 12'h000;
	localparam logic [11:0] ADDR_OUT_POLARITY = 12'h004;
	localparam logic [11:0] ADDR_BAUD_SEL = 12'h008;
	localparam logic [11:0] ADDR_FLOW_SEL = 12'h00C;
	localparam logic [11:0] ADDR_STATUS = 12'h010;
	localparam logic [11:0] ADDR_PROFILE_BASE = 12'h040; // 4 x 16 bytes
	localparam logic [11:0] ADDR_AXIS_BASE = 12'h080; // 3 x 32 bytes
	localparam logic [11:0] ADDR_AXIS_END = 12'h0E0;
	// ------------
	// ranges and reset values
	// ------------
	localparam logic [29:0] SPEED_MAX = 30'h3B9A_C9FF; // 999999999
	localparam logic [9:0] RAMP_MS_MAX = 10'h3E8; // 1000 ms
	localparam logic [19:0] TRAVEL_MAX = 20'hF_4240; // 1000000
	localparam logic [29:0] OFFSET_MAX = 30'h3B9A_C9FF;
	localparam logic [2:0] PROFILE_SEL_RST = 3'h1;
	localparam logic [29:0] MIN_SPEED_RST [4] = '{30'h0000_2710, 30'h0000_7530,
		30'h0001_1170, 30'h0001_86A0};
	localparam logic [29:0] MAX_SPEED_RST [4] = '{30'h0001_86A0, 30'h0004_93E0,
		30'h000A_AE60, 30'h000F_4240};
	localparam logic [9:0] RAMP_MS_RST = 10'h0C8;
	localparam logic [19:0] TRAVEL_RST = 20'h0_03E8;
	localparam logic [5:0] MICROSTEP_DIV = 6'h28; // driver division 40
	// zero offset falls back to 0.5 mm, counted in 0.01 um steps
	localparam int DEFAULT_OFFSET_UM = 500;
	localparam logic [29:0] DEFAULT_OFFSET = 30'(DEFAULT_OFFSET_UM * 100);
	// ------------
	// serial link timing, 250 MHz system clock
	// ------------
	localparam int CLK_HZ = 250_000_000;
	localparam logic [15:0] BAUD_DIV_9600 = 16'(CLK_HZ / 9600);
	localparam logic [15:0] BAUD_DIV_38400 = 16'(CLK_HZ / 38400);
	localparam logic [15:0] BAUD_DIV_57600 = 16'(CLK_HZ / 57600);
	localparam logic [3:0] FRAME_DATA_BITS = 4'h8;
	localparam logic [1:0] FRAME_STOP_BITS = 2'h1;
	// ------------
	// encodings
	// ------------
	typedef enum logic [1:0] {BAUD_9600 = 2'h0, BAUD_38400 = 2'h1, BAUD_57600 = 2'h2} baud_t;
	typedef enum logic [1:0] {UNIT_PULSE = 2'h0, UNIT_MICRO = 2'h1, UNIT_DEGREE = 2'h2} unit_t;
	typedef enum logic [2:0] {
		homing_disabled = 3'h0, homing_method_one = 3'h1, homing_method_two = 3'h2,
		homing_method_three = 3'h3, homing_method_four = 3'h4, homing_method_five = 3'h5,
		homing_method_six = 3'h6
	} homing_t;
	typedef enum logic [1:0] {ST_LOAD = 2'b00, ST_RUN = 2'b01} load_state_t;
	// ------------
	// carriers
	// ------------
	typedef struct packed {
		logic [29:0] min_speed; // 0.01 um/s
		logic [29:0] max_speed; // 0.01 um/s
		logic [9:0] ramp_ms;
	} profile_t;
	typedef struct packed {
		unit_t axis_display_unit;
		logic [19:0] axis_travel_per_pulse;
		logic axis_direction_polarity; // 1: negative rotation
		homing_t axis_homing_method;
		logic [29:0] axis_homing_offset;
		logic axis_auto_setup_enable;
	} axis_store_t;
	typedef struct packed {
		unit_t display_unit;
		logic [19:0] travel_per_pulse;
		logic degree_scale; // travel counted in micro-degrees
		logic [5:0] microstep_div;
		logic motor_dir;
		homing_t homing_method;
		logic homing_enable;
		logic homing_apply_offset;
		logic [29:0] homing_offset;
		logic auto_setup;
	} axis_out_t;
	typedef struct packed {
		logic [15:0] baud_div;
		baud_t baud_sel;
		logic flow_hw;
		logic [3:0] data_bits;
		logic parity_en;
		logic [1:0] stop_bits;
	} link_cfg_t;
endpackage : stage_cfg_pkg

/* File: core/stage_axis_setting_store.sv */
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module stage_axis_setting_store (
	// clock and power-on reset
	input wire logic I_CLK_SYS,
	input wire logic I_NRST,
	// apb slave
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [11:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic O_PREADY,
	output logic [31:0] O_PRDATA,
	output logic O_PSLVERR,
	// motion requests, asynchronous
	input wire logic I_JOG_ACTIVE,
	input wire logic I_PROGRAM_ACTIVE,
	input wire logic [2:0] I_AXIS_DIR_REQ,
	input wire logic [3:0] I_IO_ASSERT,
	// working settings
	output logic O_LOADED,
	output logic [2:0] O_PROFILE_SEL,
	output logic O_RUN_VALID,
	output stage_cfg_pkg::profile_t O_RUN_PROFILE,
	output stage_cfg_pkg::link_cfg_t O_LINK,
	output stage_cfg_pkg::axis_out_t [2:0] O_AXIS,
	output logic [3:0] O_IO_PIN
);
	// ------------
	// stored image, written by software
	// ------------
	logic [2:0] sel_q; // power_on_profile_select, 1..4
	logic output_polarity_select_q; // 1: idle_high_polarity
	stage_cfg_pkg::baud_t baud_q;
	logic flow_hw_q;
	stage_cfg_pkg::profile_t prof_q [4];
	stage_cfg_pkg::axis_store_t axis_q [3];

	// ------------
	// working copy, captured once after power-up
	// ------------
	stage_cfg_pkg::load_state_t state_q;
	logic [2:0] run_sel_q;
	logic run_polarity_q;
	stage_cfg_pkg::baud_t run_baud_q;
	logic run_flow_q;
	stage_cfg_pkg::profile_t run_prof_q [4];
	stage_cfg_pkg::axis_store_t run_axis_q [3];

	// apb decode
	logic access; // access phase, answer already due
	logic wr_en; // write lands this edge
	logic [1:0] pidx; // profile index
	logic [1:0] pfld; // profile field
	logic [1:0] aidx; // axis index
	logic [2:0] afld; // axis field
	logic in_prof;
	logic in_axis;
	logic [31:0] rdata_d;
	logic err_d;

	// synchronisers for pin inputs
	logic [1:0] motion_s1_q;
	logic [1:0] motion_s2_q;
	logic [2:0] dir_s1_q;
	logic [2:0] dir_s2_q;
	logic [3:0] io_s1_q;
	logic [3:0] io_s2_q;

	assign pidx = I_PADDR[5:4];
	assign pfld = I_PADDR[3:2];
	assign aidx = I_PADDR[6:5];
	assign afld = I_PADDR[4:2];
	assign in_prof = (I_PADDR >= stage_cfg_pkg::ADDR_PROFILE_BASE)
		&& (I_PADDR < stage_cfg_pkg::ADDR_AXIS_BASE);
	assign in_axis = (I_PADDR >= stage_cfg_pkg::ADDR_AXIS_BASE)
		&& (I_PADDR < stage_cfg_pkg::ADDR_AXIS_END);
	assign access = I_PSEL && I_PENABLE && O_PREADY;

	// ------------
	// read mux and range check
	// ------------
	// out-of-range values and unmapped or misaligned addresses error;
	// a refused write leaves the store untouched
	always_comb begin
		rdata_d = 32'h0000_0000;
		err_d = 1'b0;
		if (I_PADDR[1:0] != 2'b00) begin
			err_d = 1'b1;
		end else if (in_prof && pfld != 2'h3) begin
			case (pfld)
				2'h0: begin
					rdata_d = {2'b00, prof_q[pidx].min_speed};
					err_d = I_PWRITE && (I_PWDATA == 32'h0000_0000
						|| I_PWDATA > {2'b00, stage_cfg_pkg::SPEED_MAX}); // RULE2
				end
				2'h1: begin
					rdata_d = {2'b00, prof_q[pidx].max_speed};
					err_d = I_PWRITE && (I_PWDATA == 32'h0000_0000
						|| I_PWDATA > {2'b00, stage_cfg_pkg::SPEED_MAX}); // RULE2
				end
				default: begin
					rdata_d = {22'h00_0000, prof_q[pidx].ramp_ms};
					err_d = I_PWRITE && (I_PWDATA == 32'h0000_0000
						|| I_PWDATA > {22'h00_0000, stage_cfg_pkg::RAMP_MS_MAX}); // RULE2
				end
			endcase
		end else if (in_axis && afld < 3'h6) begin
			case (afld)
				3'h0: begin
					rdata_d = {30'h0000_0000, axis_q[aidx].axis_display_unit};
					err_d = I_PWRITE && I_PWDATA > 32'h0000_0002; // RULE9
				end
				3'h1: begin
					rdata_d = {12'h000, axis_q[aidx].axis_travel_per_pulse};
					err_d = I_PWRITE && (I_PWDATA == 32'h0000_0000
						|| I_PWDATA > {12'h000, stage_cfg_pkg::TRAVEL_MAX}); // RULE10
				end
				3'h2: begin
					rdata_d = {31'h0000_0000, axis_q[aidx].axis_direction_polarity};
					err_d = I_PWRITE && I_PWDATA > 32'h0000_0001;
				end
				3'h3: begin
					rdata_d = {29'h0000_0000, axis_q[aidx].axis_homing_method};
					err_d = I_PWRITE && I_PWDATA > 32'h0000_0006; // RULE13
				end
				3'h4: begin
					rdata_d = {2'b00, axis_q[aidx].axis_homing_offset};
					err_d = I_PWRITE && I_PWDATA > {2'b00, stage_cfg_pkg::OFFSET_MAX}; // RULE14
				end
				default: begin
					rdata_d = {31'h0000_0000, axis_q[aidx].axis_auto_setup_enable};
					err_d = I_PWRITE && I_PWDATA > 32'h0000_0001;
				end
			endcase
		end else begin
			case (I_PADDR)
				stage_cfg_pkg::ADDR_PROFILE_SEL: begin
					rdata_d = {29'h0000_0000, sel_q};
					err_d = I_PWRITE && (I_PWDATA == 32'h0000_0000
						|| I_PWDATA > 32'h0000_0004); // RULE1
				end
				stage_cfg_pkg::ADDR_OUT_POLARITY: begin
					rdata_d = {31'h0000_0000, output_polarity_select_q};
					err_d = I_PWRITE && I_PWDATA > 32'h0000_0001;
				end
				stage_cfg_pkg::ADDR_BAUD_SEL: begin
					rdata_d = {30'h0000_0000, baud_q};
					err_d = I_PWRITE && I_PWDATA > 32'h0000_0002; // RULE6
				end
				stage_cfg_pkg::ADDR_FLOW_SEL: begin
					rdata_d = {31'h0000_0000, flow_hw_q};
					err_d = I_PWRITE && I_PWDATA > 32'h0000_0001; // RULE8
				end
				stage_cfg_pkg::ADDR_STATUS: begin
					// read-only view of what is actually running
					rdata_d = {24'h00_0000, run_baud_q, run_flow_q, run_polarity_q,
						run_sel_q, state_q == stage_cfg_pkg::ST_RUN};
					err_d = I_PWRITE;
				end
				default: begin
					err_d = 1'b1; // unmapped
				end
			endcase
		end
	end

	// ------------
	// apb answer: one wait state, so every answer leaves a flop
	// ------------
	always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
		if (!I_NRST) begin
			O_PREADY <= 1'b0;
			O_PRDATA <= 32'h0000_0000;
			O_PSLVERR <= 1'b0;
		end else begin
			O_PREADY <= I_PSEL && I_PENABLE && !O_PREADY;
			// read data and error are presented together with pready
			O_PRDATA <= (I_PSEL && !I_PWRITE && !err_d) ? rdata_d : 32'h0000_0000;
			O_PSLVERR <= I_PSEL && I_PENABLE && !O_PREADY && err_d;
		end
	end

	assign wr_en = access && I_PWRITE && !O_PSLVERR;

	// ------------
	// stored image, defaults at power-on
	// ------------
	// the store may change at any time; it steers nothing, since a
	// power-up reset returns it to its defaults before the load
	always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
		if (!I_NRST) begin
			sel_q <= stage_cfg_pkg::PROFILE_SEL_RST; // RULE1
			output_polarity_select_q <= 1'b0; // RULE5
			baud_q <= stage_cfg_pkg::BAUD_38400; // RULE6
			flow_hw_q <= 1'b1; // RULE8
			for (int p = 0; p < 4; p++) begin
				prof_q[p].min_speed <= stage_cfg_pkg::MIN_SPEED_RST[p]; // RULE2
				prof_q[p].max_speed <= stage_cfg_pkg::MAX_SPEED_RST[p];
				prof_q[p].ramp_ms <= stage_cfg_pkg::RAMP_MS_RST;
			end
			for (int a = 0; a < 3; a++) begin
				axis_q[a].axis_display_unit <= stage_cfg_pkg::UNIT_MICRO; // RULE9
				axis_q[a].axis_travel_per_pulse <= stage_cfg_pkg::TRAVEL_RST; // RULE10
				axis_q[a].axis_direction_polarity <= 1'b0; // RULE12
				axis_q[a].axis_homing_method <= stage_cfg_pkg::homing_method_one; // RULE13
				axis_q[a].axis_homing_offset <= 30'h0000_0000;
				axis_q[a].axis_auto_setup_enable <= 1'b1; // RULE16
			end
		end else if (wr_en) begin
			if (in_prof) begin
				case (pfld)
					2'h0: prof_q[pidx].min_speed <= I_PWDATA[29:0];
					2'h1: prof_q[pidx].max_speed <= I_PWDATA[29:0];
					default: prof_q[pidx].ramp_ms <= I_PWDATA[9:0];
				endcase
			end else if (in_axis) begin
				case (afld)
					3'h0: axis_q[aidx].axis_display_unit <= stage_cfg_pkg::unit_t'(I_PWDATA[1:0]);
					3'h1: axis_q[aidx].axis_travel_per_pulse <= I_PWDATA[19:0];
					3'h2: axis_q[aidx].axis_direction_polarity <= I_PWDATA[0];
					3'h3: axis_q[aidx].axis_homing_method <= stage_cfg_pkg::homing_t'(I_PWDATA[2:0]);
					3'h4: axis_q[aidx].axis_homing_offset <= I_PWDATA[29:0];
					default: axis_q[aidx].axis_auto_setup_enable <= I_PWDATA[0];
				endcase
			end else begin
				case (I_PADDR)
					stage_cfg_pkg::ADDR_PROFILE_SEL: sel_q <= I_PWDATA[2:0];
					stage_cfg_pkg::ADDR_OUT_POLARITY: output_polarity_select_q <= I_PWDATA[0];
					stage_cfg_pkg::ADDR_BAUD_SEL: baud_q <= stage_cfg_pkg::baud_t'(I_PWDATA[1:0]);
					stage_cfg_pkg::ADDR_FLOW_SEL: flow_hw_q <= I_PWDATA[0];
					default: sel_q <= sel_q; // status is read-only
				endcase
			end
		end
	end

	// ------------
	// power-up load: one copy, then frozen
	// ------------
	always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
		if (!I_NRST) begin
			state_q <= stage_cfg_pkg::ST_LOAD;
		end else begin
			case (state_q)
				stage_cfg_pkg::ST_LOAD: state_q <= stage_cfg_pkg::ST_RUN;
				stage_cfg_pkg::ST_RUN: state_q <= stage_cfg_pkg::ST_RUN;
				default: state_q <= stage_cfg_pkg::ST_LOAD;
			endcase
		end
	end

	// working registers take the store only in the load state
	always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
		if (!I_NRST) begin
			run_sel_q <= stage_cfg_pkg::PROFILE_SEL_RST;
			run_polarity_q <= 1'b0;
			run_baud_q <= stage_cfg_pkg::BAUD_38400;
			run_flow_q <= 1'b1;
			for (int p = 0; p < 4; p++) begin
				run_prof_q[p] <= '{stage_cfg_pkg::MIN_SPEED_RST[p],
					stage_cfg_pkg::MAX_SPEED_RST[p], stage_cfg_pkg::RAMP_MS_RST};
			end
			for (int a = 0; a < 3; a++) begin
				run_axis_q[a] <= '{stage_cfg_pkg::UNIT_MICRO, stage_cfg_pkg::TRAVEL_RST,
					1'b0, stage_cfg_pkg::homing_method_one, 30'h0000_0000, 1'b1};
			end
		end else if (state_q == stage_cfg_pkg::ST_LOAD) begin // RULE19
			run_sel_q <= sel_q; // RULE1
			run_polarity_q <= output_polarity_select_q;
			run_baud_q <= baud_q;
			run_flow_q <= flow_hw_q;
			run_prof_q <= prof_q;
			run_axis_q <= axis_q;
		end
	end

	// ------------
	// pin synchronisers
	// ------------
	always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
		if (!I_NRST) begin
			motion_s1_q <= 2'b00;
			motion_s2_q <= 2'b00;
			dir_s1_q <= 3'b000;
			dir_s2_q <= 3'b000;
			io_s1_q <= 4'h0;
			io_s2_q <= 4'h0;
		end else begin
			motion_s1_q <= {I_PROGRAM_ACTIVE, I_JOG_ACTIVE};
			motion_s2_q <= motion_s1_q;
			dir_s1_q <= I_AXIS_DIR_REQ;
			dir_s2_q <= dir_s1_q;
			io_s1_q <= I_IO_ASSERT;
			io_s2_q <= io_s1_q;
		end
	end

	// ------------
	// global outputs
	// ------------
	// profile speeds are presented only while joystick or program
	// motion runs; zero speeds elsewhere keep a stray start harmless
	always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
		if (!I_NRST) begin
			O_LOADED <= 1'b0;
			O_PROFILE_SEL <= stage_cfg_pkg::PROFILE_SEL_RST;
			O_RUN_VALID <= 1'b0;
			O_RUN_PROFILE <= '0;
			O_LINK <= '0;
			O_IO_PIN <= 4'h0;
		end else begin
			O_LOADED <= state_q == stage_cfg_pkg::ST_RUN;
			O_PROFILE_SEL <= run_sel_q;
			O_RUN_VALID <= |motion_s2_q; // RULE4
			O_RUN_PROFILE <= (|motion_s2_q) ? run_prof_q[2'(run_sel_q - 3'h1)] : '0; // RULE4
			case (run_baud_q)
				stage_cfg_pkg::BAUD_9600: O_LINK.baud_div <= stage_cfg_pkg::BAUD_DIV_9600; // RULE6
				stage_cfg_pkg::BAUD_57600: O_LINK.baud_div <= stage_cfg_pkg::BAUD_DIV_57600;
				default: O_LINK.baud_div <= stage_cfg_pkg::BAUD_DIV_38400;
			endcase
			O_LINK.baud_sel <= run_baud_q;
			O_LINK.flow_hw <= run_flow_q; // RULE8
			O_LINK.data_bits <= stage_cfg_pkg::FRAME_DATA_BITS; // RULE7
			O_LINK.parity_en <= 1'b0; // RULE7
			O_LINK.stop_bits <= stage_cfg_pkg::FRAME_STOP_BITS; // RULE7
			// idle level follows the polarity: low when active high
			O_IO_PIN <= io_s2_q ^ {4{run_polarity_q}}; // RULE5
		end
	end

	// ------------
	// per axis outputs
	// ------------
	for (genvar a = 0; a < 3; a++) begin : g_axis
		always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
			if (!I_NRST) begin
				O_AXIS[a] <= '0;
			end else begin
				O_AXIS[a].display_unit <= run_axis_q[a].axis_display_unit; // RULE9
				O_AXIS[a].travel_per_pulse <= run_axis_q[a].axis_travel_per_pulse; // RULE10
				O_AXIS[a].microstep_div <= stage_cfg_pkg::MICROSTEP_DIV; // RULE10
				O_AXIS[a].degree_scale <=
					run_axis_q[a].axis_display_unit == stage_cfg_pkg::UNIT_DEGREE; // RULE11
				O_AXIS[a].motor_dir <= dir_s2_q[a] ^ run_axis_q[a].axis_direction_polarity; // RULE12
				O_AXIS[a].homing_method <= run_axis_q[a].axis_homing_method; // RULE13
				O_AXIS[a].homing_enable <=
					run_axis_q[a].axis_homing_method != stage_cfg_pkg::homing_disabled; // RULE18
				O_AXIS[a].homing_apply_offset <=
					run_axis_q[a].axis_homing_method == stage_cfg_pkg::homing_method_one
					|| run_axis_q[a].axis_homing_method == stage_cfg_pkg::homing_method_five
					|| run_axis_q[a].axis_homing_method == stage_cfg_pkg::homing_method_six; // RULE14
				if (run_axis_q[a].axis_homing_offset == 30'h0000_0000) begin
					O_AXIS[a].homing_offset <= stage_cfg_pkg::DEFAULT_OFFSET; // RULE15
				end else begin
					O_AXIS[a].homing_offset <= run_axis_q[a].axis_homing_offset;
				end
				O_AXIS[a].auto_setup <= run_axis_q[a].axis_auto_setup_enable; // RULE16
			end
		end
	end
endmodule : stage_axis_setting_store

/* File: bench/stage_axis_setting_store_checker.sv */
`timescale 1ns/1ps
module stage_axis_setting_store_checker (
	// clock and power-on reset
	input wire logic I_CLK_SYS,
	input wire logic I_NRST,
	// bus handshake and motion requests
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_JOG_ACTIVE,
	input wire logic I_PROGRAM_ACTIVE,
	input wire logic [2:0] I_AXIS_DIR_REQ,
	input wire logic [3:0] I_IO_ASSERT,
	// outputs under watch
	input wire logic O_PREADY,
	input wire logic O_LOADED,
	input wire logic [2:0] O_PROFILE_SEL,
	input wire logic O_RUN_VALID,
	input wire stage_cfg_pkg::profile_t O_RUN_PROFILE,
	input wire stage_cfg_pkg::link_cfg_t O_LINK,
	input wire stage_cfg_pkg::axis_out_t [2:0] O_AXIS,
	input wire logic [3:0] O_IO_PIN
);
	// ------------
	// one clock domain, reset disables everything
	// ------------
	default clocking cb @(posedge I_CLK_SYS);
	endclocking
	default disable iff (!I_NRST);
	// access phase still waiting for its answer
	sequence access_s;
		I_PSEL && I_PENABLE && !O_PREADY;
	endsequence
	// answer lasts exactly one cycle
	sequence answer_s;
		O_PREADY ##1 !O_PREADY;
	endsequence
	// ------------
	// assertions
	// ------------
	pready_pulse_a: assert property (access_s |=> answer_s)
		else $error("bus answer not one cycle after access");
	boot_profile_a: assert property ($rose(O_LOADED) |-> O_PROFILE_SEL == 3'h1)
		else $error("working profile not one at load");
	working_hold_a: assert property (O_LOADED |=> $stable(O_PROFILE_SEL) && $stable(O_LINK))
		else $error("working settings moved after load");
	run_profile_a: assert property (O_RUN_VALID && O_PROFILE_SEL == 3'h1 |->
		O_RUN_PROFILE == {30'h0000_2710, 30'h0001_86A0, 10'h0C8})
		else $error("running profile differs from profile one");
	// three edges of lag: two sync flops and an output flop
	run_follow_a: assert property (O_LOADED && $past(O_LOADED, 3) |->
		O_RUN_VALID == ($past(I_JOG_ACTIVE, 3) | $past(I_PROGRAM_ACTIVE, 3)))
		else $error("run flag does not follow motion requests");
	io_polarity_a: assert property (O_LOADED && $past(O_LOADED, 3) |->
		O_IO_PIN == $past(I_IO_ASSERT, 3))
		else $error("output pins not idle low after power-up");
	motor_dir_a: assert property (O_LOADED && $past(O_LOADED, 3) |->
		{O_AXIS[2].motor_dir, O_AXIS[1].motor_dir, O_AXIS[0].motor_dir} == $past(I_AXIS_DIR_REQ, 3))
		else $error("motor direction not mapped positive");
	link_frame_a: assert property (O_LOADED |-> O_LINK.data_bits == 4'h8 &&
		!O_LINK.parity_en && O_LINK.stop_bits == 2'h1 && O_LINK.baud_div == 16'h196E)
		else $error("serial framing or rate wrong");
	home_offset_a: assert property (O_LOADED |-> O_AXIS[0].homing_apply_offset &&
		O_AXIS[0].homing_offset == 30'h0000_C350)
		else $error("zero offset not replaced by half a millimetre");
endmodule : stage_axis_setting_store_checker

bind stage_axis_setting_store stage_axis_setting_store_checker stage_axis_setting_store_checker_i (
	.I_CLK_SYS(I_CLK_SYS), .I_NRST(I_NRST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
	.I_JOG_ACTIVE(I_JOG_ACTIVE), .I_PROGRAM_ACTIVE(I_PROGRAM_ACTIVE),
	.I_AXIS_DIR_REQ(I_AXIS_DIR_REQ), .I_IO_ASSERT(I_IO_ASSERT), .O_PREADY(O_PREADY),
	.O_LOADED(O_LOADED), .O_PROFILE_SEL(O_PROFILE_SEL), .O_RUN_VALID(O_RUN_VALID),
	.O_RUN_PROFILE(O_RUN_PROFILE), .O_LINK(O_LINK), .O_AXIS(O_AXIS), .O_IO_PIN(O_IO_PIN));

/* File: bench/host_model.sv */
`timescale 1ns/1ps
module host_model (
	// bus clock and slave answer
	input wire logic clk,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	// request side
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata
);
	// ------------
	// host serial settings, must match the stored defaults
	// ------------
	localparam logic [31:0] host_rate = 32'h0000_9600;
	localparam logic [3:0] host_data_bits = 4'h8;
	localparam logic host_flow_hw = 1'b1;
	// idle bus from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end
	// one transfer; waits a fresh edge so back-to-back calls never collide
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// request held until pready is seen at a rising edge
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : host_model

/* File: bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
	// ------------
	// signals
	// ------------
	logic clk, nrst, psel, penable, pwrite, pready, pslverr, jog, prog, loaded, run_valid;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [2:0] dir_req, prof_sel;
	logic [3:0] io_assert, io_pin;
	stage_cfg_pkg::profile_t run_prof;
	stage_cfg_pkg::link_cfg_t link;
	stage_cfg_pkg::axis_out_t [2:0] axis;
	int err_total = 0;
	int compares = 0;
	// default profiles: min, max, ramp for profiles one to four
	logic [31:0] pdef [12] = '{32'h2710, 32'h1_86A0, 32'hC8, 32'h7530, 32'h4_93E0, 32'hC8,
		32'h1_1170, 32'hA_AE60, 32'hC8, 32'h1_86A0, 32'hF_4240, 32'hC8};
	// write table: address, data, refusal expected
	logic [44:0] wt [27] = '{{12'h000, 32'h0, 1'b1}, {12'h000, 32'h5, 1'b1},
		{12'h000, 32'h4, 1'b0}, {12'h040, 32'h0, 1'b1}, {12'h044, 32'h3B9A_CA00, 1'b1},
		{12'h048, 32'h3E9, 1'b1}, {12'h048, 32'h3E8, 1'b0}, {12'h040, 32'h1, 1'b0},
		{12'h004, 32'h2, 1'b1}, {12'h004, 32'h1, 1'b0}, {12'h008, 32'h3, 1'b1},
		{12'h008, 32'h0, 1'b0}, {12'h008, 32'h2, 1'b0}, {12'h00C, 32'h2, 1'b1},
		{12'h00C, 32'h0, 1'b0}, {12'h080, 32'h3, 1'b1}, {12'h0C0, 32'h2, 1'b0},
		{12'h084, 32'h0, 1'b1}, {12'h084, 32'hF_4241, 1'b1}, {12'h084, 32'hF_4240, 1'b0},
		{12'h088, 32'h1, 1'b0}, {12'h08C, 32'h7, 1'b1}, {12'h090, 32'h3B9A_C9FF, 1'b0},
		{12'h090, 32'h3B9A_CA00, 1'b1}, {12'h094, 32'h0, 1'b0}, {12'h094, 32'h2, 1'b1},
		{12'h010, 32'h0, 1'b1}};
	// ------------
	// design and host
	// ------------
	stage_axis_setting_store stage_axis_setting_store_i (.I_CLK_SYS(clk), .I_NRST(nrst),
		.I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
		.I_PWDATA(pwdata), .O_PREADY(pready), .O_PRDATA(prdata), .O_PSLVERR(pslverr),
		.I_JOG_ACTIVE(jog), .I_PROGRAM_ACTIVE(prog), .I_AXIS_DIR_REQ(dir_req),
		.I_IO_ASSERT(io_assert), .O_LOADED(loaded), .O_PROFILE_SEL(prof_sel),
		.O_RUN_VALID(run_valid), .O_RUN_PROFILE(run_prof), .O_LINK(link), .O_AXIS(axis),
		.O_IO_PIN(io_pin));
	host_model host_model_i (.clk(clk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
	// 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// ------------
	// helpers
	// ------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// one bus access; a read compares its data against d
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic ee);
		logic [31:0] v;
		logic r;
		host_model_i.xfer(w, a, d, v, r);
		if (!w) chk(v, d);
		chk({31'h0, r}, {31'h0, ee});
	endtask : bus
	// bounded wait for the power-up load
	task automatic wait_load;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (loaded !== 1'b1 && n < 20);
		chk({31'h0, loaded}, 32'h1);
	endtask : wait_load
	// ------------
	// scenarios
	// ------------
	task automatic t_defaults;
		wait_load();
		chk({29'h0, prof_sel}, 32'h1);
		chk({16'h0, link.baud_div}, 32'h0EE6_B280 / host_model_i.host_rate);
		chk({28'h0, link.data_bits}, {28'h0, host_model_i.host_data_bits});
		chk({29'h0, link.parity_en, link.stop_bits}, 32'h1);
		chk({31'h0, link.flow_hw}, {31'h0, host_model_i.host_flow_hw});
		for (int a = 0; a < 3; a++) begin
			chk({30'h0, axis[a].display_unit}, 32'h1);
			chk(32'({axis[a].degree_scale, axis[a].microstep_div, axis[a].travel_per_pulse}),
				32'h0280_03E8);
			chk(32'({axis[a].homing_method, axis[a].homing_enable, axis[a].homing_apply_offset,
				axis[a].auto_setup}), 32'hF);
			chk({2'h0, axis[a].homing_offset}, 32'h0000_C350);
		end
	endtask : t_defaults
	task automatic t_regs;
		for (int p = 0; p < 4; p++) begin
			for (int f = 0; f < 3; f++) begin
				bus(1'b0, 12'(16 * p + 4 * f + 64), pdef[3 * p + f], 1'b0);
			end
		end
		bus(1'b0, 12'h04C, 32'h0, 1'b1);
		bus(1'b0, 12'h010, 32'h63, 1'b0);
		bus(1'b0, 12'h004, 32'h0, 1'b0);
	endtask : t_regs
	// stored values change, working copy must not
	task automatic t_writes;
		foreach (wt[i]) begin
			bus(1'b1, wt[i][44:33], wt[i][32:1], wt[i][0]);
			if (!wt[i][0]) bus(1'b0, wt[i][44:33], wt[i][32:1], 1'b0);
		end
		bus(1'b0, 12'h090, 32'h3B9A_C9FF, 1'b0);
		bus(1'b0, 12'h094, 32'h0, 1'b0);
		for (int m = 0; m < 7; m++) begin
			bus(1'b1, 12'h0CC, 32'(m), 1'b0);
			bus(1'b0, 12'h0CC, 32'(m), 1'b0);
		end
		bus(1'b0, 12'h010, 32'h63, 1'b0);
		chk({16'h0, link.baud_div}, 32'h196E);
	endtask : t_writes
	// motion request, then outputs after sync lag
	task automatic step(input logic j, input logic p, input logic [3:0] io, input logic [2:0] d);
		@(posedge clk);
		jog <= j;
		prog <= p;
		io_assert <= io;
		dir_req <= d;
		repeat (4) @(posedge clk);
		#1;
		chk({31'h0, run_valid}, {31'h0, j | p});
		chk(32'(run_prof), (j | p) ? 32'(70'h09C4_0061_A80C8) : 32'h0);
		chk({28'h0, io_pin}, {28'h0, io});
		chk(32'({axis[2].motor_dir, axis[1].motor_dir, axis[0].motor_dir}), {29'h0, d});
	endtask : step
	task automatic t_motion;
		step(1'b1, 1'b0, 4'hA, 3'h5);
		step(1'b0, 1'b1, 4'h5, 3'h2);
		step(1'b0, 1'b0, 4'h0, 3'h0);
	endtask : t_motion
	// power cycle brings the store and working copy back together
	task automatic t_power;
		@(posedge clk);
		nrst <= 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		t_defaults();
		bus(1'b0, 12'h000, 32'h1, 1'b0);
	endtask : t_power
	// ------------
	// run control
	// ------------
	task automatic test_done;
		$display("TB: %0d mismatches in %0d compares", err_total, compares);
		if (err_total == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : test_done
	initial begin
		nrst = 1'b0;
		jog = 1'b0;
		prog = 1'b0;
		dir_req = 3'h0;
		io_assert = 4'h0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		t_defaults();
		t_regs();
		t_writes();
		t_motion();
		t_power();
		test_done();
	end
	// hang guard, far beyond the 72 transfers above
	initial begin
		repeat (8000) @(posedge clk);
		err_total++;
		test_done();
	end
endmodule : testbench
